// *** hdl/jog_class_pick.v ***
/*
  Speed class priority picker for jog requests.
  Assumes the three select bits are synchronous to the clock.
*/
`timescale 1ns/1ps
`include "rsj_defines.vh"
module jog_class_pick (
  input  wire                  i_inch,
  input  wire                  i_low,
  input  wire                  i_high,
  output wire                  o_valid,
  output reg  [`RSJ_SPD_W-1:0] o_class
);

  assign o_valid = i_inch | i_low | i_high;

  always @* begin
    if (i_inch) begin
      o_class = `RSJ_SPD_INCH;
    end else if (i_low) begin
      o_class = `RSJ_SPD_LOW;
    end else begin
      o_class = `RSJ_SPD_HIGH;
    end
  end

endmodule // jog_class_pick

// *** hdl/remote_sys_jog.v ***
/*
  Remote system control and jog handshake logic of a robot controller
  acting as a fieldbus remote device station.
  Assumes the fieldbus interface delivers request bits synchronous to
  I_CLK, and a motion core consumes the command pulses and reports state.
*/
`timescale 1ns/1ps
`include "rsj_defines.vh"
module remote_sys_jog (
  input  wire                  I_CLK,
  input  wire                  I_SRST,
  // Mode and environment
  input  wire                  i_EXT_POINT_MODE,
  input  wire                  i_LINK_OK,
  input  wire                  i_PENDANT_ACTIVE,
  input  wire                  i_PC_SW_ACTIVE,
  // System request bits from the master
  input  wire                  i_HOME_REQUEST_BIT,
  input  wire                  i_START_REQUEST_BIT,
  input  wire                  i_STOP_REQUEST_BIT,
  input  wire                  i_ERROR_RESET_REQUEST_BIT,
  // Jog request bits from the master
  input  wire [`RSJ_AXES-1:0]  i_AXIS_JOG_REQUEST,
  input  wire                  i_INCHING_SELECT,
  input  wire                  i_LOW_SPEED_JOG_SELECT,
  input  wire                  i_HIGH_SPEED_JOG_SELECT,
  input  wire                  i_JOG_DIRECTION_SELECT,
  // Motion core state
  input  wire                  i_PROG_EXECUTING,
  input  wire                  i_HOMING,
  input  wire                  i_ROBOT_MOVING,
  input  wire                  i_AT_TARGET,
  input  wire                  i_PAUSED,
  input  wire                  i_ALL_AXES_HOME,
  input  wire                  i_HOME_DONE,
  input  wire                  i_ERROR_EVENT,
  // Commands to the motion core
  output reg                   o_HOME_CMD,
  output reg                   o_START_CMD,
  output reg                   o_STEP_HALT,
  output reg                   o_ERROR_CLEAR,
  output reg  [`RSJ_AXES-1:0]  o_JOG_AXIS_MOVE,
  output reg  [`RSJ_SPD_W-1:0] o_JOG_SPEED,
  output reg                   o_JOG_DIR,
  // Status bits to the master
  output reg                   o_RUNNING_STATUS_BIT,
  output reg                   o_ERROR_STATUS_BIT,
  output reg                   o_IN_POSITION_STATUS_BIT,
  output reg                   o_HOMED_STATUS_BIT,
  output reg  [`RSJ_AXES-1:0]  o_AXIS_JOGGING,
  output reg                   o_JOG_READY,
  output wire [`RSJ_SPARE_BITS-1:0] o_SPARE_STATUS
);

  // Lowest set bit of a request vector, so a burst of several
  // rising requests still yields a single axis
  function [`RSJ_AXES-1:0] lowest_bit;
    input [`RSJ_AXES-1:0] v;
    begin
      lowest_bit = v & (~v + 4'h1);
    end
  endfunction

  wire [1:0]                sys_rise;
  wire [`RSJ_AXES-1:0]      jog_rise;
  wire                      class_valid;
  wire [`RSJ_SPD_W-1:0]     class_pick;
  wire [`RSJ_AXES-1:0]      axis_pick;
  wire                      normal_mode;
  wire                      stop_blocks;
  wire                      home_go;
  wire                      start_go;
  wire                      clear_ok;
  wire                      jog_accept;
  wire                      jog_end;
  wire                      ready_next;
  wire                      running_next;
  wire                      error_next;
  wire                      in_pos_next;
  wire                      homed_next;

  reg                       state_reg;
  reg                       state_next;
  reg  [`RSJ_AXES-1:0]      axis_reg;
  reg  [`RSJ_AXES-1:0]      axis_next;
  reg  [`RSJ_SPD_W-1:0]     speed_reg;
  reg  [`RSJ_SPD_W-1:0]     speed_next;
  reg                       dir_reg;
  reg                       dir_next;

  rise_detect #(
    .W (2)
  ) u_sys_edge (
    .i_clk   (I_CLK),
    .i_srst  (I_SRST),
    .i_level ({i_START_REQUEST_BIT, i_HOME_REQUEST_BIT}),
    .o_rise  (sys_rise)
  );

  rise_detect #(
    .W (`RSJ_AXES)
  ) u_jog_edge (
    .i_clk   (I_CLK),
    .i_srst  (I_SRST),
    .i_level (i_AXIS_JOG_REQUEST),
    .o_rise  (jog_rise)
  );

  jog_class_pick u_class (
    .i_inch  (i_INCHING_SELECT),
    .i_low   (i_LOW_SPEED_JOG_SELECT),
    .i_high  (i_HIGH_SPEED_JOG_SELECT),
    .o_valid (class_valid),
    .o_class (class_pick)
  );

  assign normal_mode = ~i_EXT_POINT_MODE;

  // Stop only gates requests in normal mode; external mode ignores it
  assign stop_blocks = i_STOP_REQUEST_BIT & normal_mode;

  // Home acts on the edge only, a held level does not retrigger
  assign home_go = sys_rise[0] & ~stop_blocks;

  // Start is edge-triggered so one press gives one resume
  assign start_go = sys_rise[1] & ~stop_blocks;

  // In normal mode an error may only be cleared with the program stopped
  assign clear_ok = i_ERROR_RESET_REQUEST_BIT &
                    (i_EXT_POINT_MODE | ~i_PROG_EXECUTING);

  always @(posedge I_CLK) begin
    if (I_SRST) begin
      o_HOME_CMD    <= 1'b0;
      o_START_CMD   <= 1'b0;
      o_STEP_HALT   <= 1'b0;
      o_ERROR_CLEAR <= 1'b0;
    end else begin
      o_HOME_CMD    <= home_go;
      o_START_CMD   <= start_go;
      o_STEP_HALT   <= stop_blocks;
      o_ERROR_CLEAR <= clear_ok & o_ERROR_STATUS_BIT;
    end
  end

  // Status bits

  assign running_next = normal_mode ? (i_PROG_EXECUTING | i_HOMING)
                                    : i_ROBOT_MOVING;

  // A new error wins over a clear in the same cycle
  assign error_next = i_ERROR_EVENT |
                      (o_ERROR_STATUS_BIT & ~clear_ok);

  assign in_pos_next = i_AT_TARGET & ~i_ROBOT_MOVING & ~i_PAUSED;

  // Homed drops on any new home command or when an axis leaves home
  assign homed_next = i_ALL_AXES_HOME & ~home_go &
                      ((i_HOME_DONE) | o_HOMED_STATUS_BIT);

  always @(posedge I_CLK) begin
    if (I_SRST) begin
      o_RUNNING_STATUS_BIT     <= 1'b0;
      o_ERROR_STATUS_BIT       <= 1'b0;
      o_IN_POSITION_STATUS_BIT <= 1'b0;
      o_HOMED_STATUS_BIT       <= 1'b0;
    end else begin
      o_RUNNING_STATUS_BIT     <= running_next;
      o_ERROR_STATUS_BIT       <= error_next;
      o_IN_POSITION_STATUS_BIT <= in_pos_next;
      o_HOMED_STATUS_BIT       <= homed_next;
    end
  end

  // Jog sequencer

  // Ready is registered from the next-cycle state and status values, so the master and
  // the acceptance logic look at the same value
  assign ready_next = (state_next == `RSJ_ST_IDLE) &
                      ~i_PENDANT_ACTIVE &
                      ~i_PC_SW_ACTIVE &
                      ~running_next &
                      ~error_next;

  assign axis_pick = lowest_bit(jog_rise);

  // A request with no speed class is refused rather than guessed
  assign jog_accept = o_JOG_READY & (|jog_rise) & class_valid;

  assign jog_end = ~(|(i_AXIS_JOG_REQUEST & axis_reg)) | ~i_LINK_OK;

  always @* begin
    state_next = state_reg;
    axis_next  = axis_reg;
    speed_next = speed_reg;
    dir_next   = dir_reg;
    case (state_reg)
      `RSJ_ST_IDLE: begin
        if (jog_accept) begin
          state_next = `RSJ_ST_JOG;
          axis_next  = axis_pick;
          speed_next = class_pick;
          dir_next   = i_JOG_DIRECTION_SELECT;
        end
      end
      `RSJ_ST_JOG: begin
        // Select bits are not looked at here, so changes mid-jog are ignored
        if (jog_end) begin
          state_next = `RSJ_ST_IDLE;
          axis_next  = `RSJ_AXIS_RST;
        end
      end
      default: begin
        state_next = `RSJ_ST_IDLE;
        axis_next  = `RSJ_AXIS_RST;
      end
    endcase
  end

  always @(posedge I_CLK) begin
    if (I_SRST) begin
      state_reg <= `RSJ_ST_IDLE;
      axis_reg  <= `RSJ_AXIS_RST;
      speed_reg <= `RSJ_SPD_INCH;
      dir_reg   <= `RSJ_DIR_PLUS;
    end else begin
      state_reg <= state_next;
      axis_reg  <= axis_next;
      speed_reg <= speed_next;
      dir_reg   <= dir_next;
    end
  end

  // Status flips in the accept cycle; motion follows one cycle later,
  // and on release motion and status drop together
  always @(posedge I_CLK) begin
    if (I_SRST) begin
      o_AXIS_JOGGING  <= `RSJ_AXIS_RST;
      o_JOG_READY     <= 1'b0;
      o_JOG_AXIS_MOVE <= `RSJ_AXIS_RST;
      o_JOG_SPEED     <= `RSJ_SPD_INCH;
      o_JOG_DIR       <= `RSJ_DIR_PLUS;
    end else begin
      o_AXIS_JOGGING  <= axis_next;
      o_JOG_READY     <= ready_next;
      o_JOG_AXIS_MOVE <= (state_reg == `RSJ_ST_JOG && !jog_end) ? axis_reg
                                                               : `RSJ_AXIS_RST;
      o_JOG_SPEED     <= speed_reg;
      o_JOG_DIR       <= dir_reg;
    end
  end

  assign o_SPARE_STATUS = `RSJ_SPARE_VAL;

endmodule // remote_sys_jog

// *** hdl/rise_detect.v ***
/*
  Rising edge detector for a vector of request bits.
  Assumes inputs synchronous to the clock.
*/
`timescale 1ns/1ps
module rise_detect #(
  parameter W = 4
) (
  input  wire         i_clk,
  input  wire         i_srst,
  input  wire [W-1:0] i_level,
  output wire [W-1:0] o_rise
);

  reg [W-1:0] prev_reg;

  // Previous sample clears to zero, so a level held through reset counts as a new edge
  always @(posedge i_clk) begin
    if (i_srst) begin
      prev_reg <= {W{1'b0}};
    end else begin
      prev_reg <= i_level;
    end
  end

  assign o_rise = i_level & ~prev_reg;

endmodule // rise_detect

// *** inc/rsj_defines.vh ***
/*
  Shared constants for the remote system and jog I/O block:
  field widths, jog state codes, speed class codes and reset values.
  Assumes inclusion by bare name from the hdl files.
*/
`ifndef RSJ_DEFINES_VH
`define RSJ_DEFINES_VH

// Number of jog axes and spare status bits
`define RSJ_AXES          4
`define RSJ_SPARE_BITS    3

// Jog sequencer state codes
`define RSJ_ST_IDLE       1'b0
`define RSJ_ST_JOG        1'b1

// Speed class codes
`define RSJ_SPD_W         2
`define RSJ_SPD_INCH      2'h0
`define RSJ_SPD_LOW       2'h1
`define RSJ_SPD_HIGH      2'h2

// Direction encoding of the direction select bit
`define RSJ_DIR_PLUS      1'b0
`define RSJ_DIR_MINUS     1'b1

// Reset values
`define RSJ_AXIS_RST      4'h0
`define RSJ_SPARE_VAL     3'h0

`endif

// *** testbench/fb_master.sv ***
/* Master station model driving the jog request bits.
   Assumes the bench calls jog() at a falling edge. */
`timescale 1ns/1ps
module fb_master (
  input  logic       clk,
  input  logic       ready,
  output logic [3:0] req,
  output logic       inch,
  output logic       low,
  output logic       high,
  output logic       dir
);
  initial begin
    req = 4'h0;
    {inch, low, high, dir} = 4'h0;
  end
  // Barge skips the ready check; conditions flip mid-jog to show they are ignored
  task jog(input logic [1:0] ax, input logic [2:0] sel, input logic d, input logic barge, input int len);
    int n;
    n = 0;
    while (!ready && !barge && n < 50) begin
      @(negedge clk);
      n++;
    end
    {inch, low, high} = sel;
    dir = d;
    @(negedge clk);
    req[ax] = 1'b1;
    repeat (len) @(negedge clk);
    {inch, low, high, dir} = ~{inch, low, high, dir};
    repeat (len) @(negedge clk);
    req = 4'h0;
    @(negedge clk);
  endtask
endmodule // fb_master

// *** testbench/rsj_sva.sv ***
/* Checker for the remote system and jog block.
   Sees only top ports; bound below to every instance. */
`timescale 1ns/1ps
module rsj_sva (
  input logic       I_CLK,
  input logic       I_SRST,
  input logic       i_EXT_POINT_MODE,
  input logic       i_LINK_OK,
  input logic       i_HOME_REQUEST_BIT,
  input logic       i_STOP_REQUEST_BIT,
  input logic       i_ERROR_RESET_REQUEST_BIT,
  input logic       i_PROG_EXECUTING,
  input logic       i_ERROR_EVENT,
  input logic [3:0] i_AXIS_JOG_REQUEST,
  input logic       o_HOME_CMD,
  input logic       o_START_CMD,
  input logic [3:0] o_JOG_AXIS_MOVE,
  input logic [1:0] o_JOG_SPEED,
  input logic       o_JOG_DIR,
  input logic       o_ERROR_STATUS_BIT,
  input logic [3:0] o_AXIS_JOGGING,
  input logic       o_JOG_READY,
  input logic [2:0] o_SPARE_STATUS
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  wire blk = i_STOP_REQUEST_BIT && !i_EXT_POINT_MODE;
  chk_home_edge: assert property ($rose(i_HOME_REQUEST_BIT) && !blk |=> o_HOME_CMD ##1 !o_HOME_CMD)
    else $error("home pulse wrong");
  chk_stop_block: assert property (blk |=> !o_HOME_CMD && !o_START_CMD)
    else $error("request passed stop");
  chk_err_set: assert property (i_ERROR_EVENT |=> o_ERROR_STATUS_BIT)
    else $error("error flag not set");
  chk_err_clear: assert property (o_ERROR_STATUS_BIT && i_ERROR_RESET_REQUEST_BIT && !i_ERROR_EVENT
    && (i_EXT_POINT_MODE || !i_PROG_EXECUTING) |=> !o_ERROR_STATUS_BIT) else $error("error not cleared");
  chk_one_axis: assert property ($onehot0(o_AXIS_JOGGING) && $onehot0(o_JOG_AXIS_MOVE))
    else $error("two axes jogging");
  chk_jog_refuse: assert property (!o_JOG_READY && o_AXIS_JOGGING == 4'h0 |=> o_AXIS_JOGGING == 4'h0)
    else $error("jog taken while not ready");
  chk_jog_start: assert property ($rose(|o_AXIS_JOGGING) |-> !o_JOG_READY ##1 o_JOG_AXIS_MOVE == o_AXIS_JOGGING)
    else $error("jog start order wrong");
  chk_jog_stop: assert property ((o_AXIS_JOGGING & ~i_AXIS_JOG_REQUEST) != 4'h0 || (|o_AXIS_JOGGING && !i_LINK_OK)
    |=> o_AXIS_JOGGING == 4'h0 && o_JOG_AXIS_MOVE == 4'h0) else $error("jog not stopped");
  chk_cond_hold: assert property (o_JOG_AXIS_MOVE != 4'h0 && $past(o_JOG_AXIS_MOVE) != 4'h0
    |-> $stable(o_JOG_SPEED) && $stable(o_JOG_DIR)) else $error("jog condition changed");
  chk_spare_low: assert property (o_SPARE_STATUS == 3'h0)
    else $error("spare bits high");
endmodule // rsj_sva
bind remote_sys_jog rsj_sva i_rsj_sva (.*);

// *** testbench/tb_remote_sys_jog.sv ***
/* Bench for the remote system and jog block with a master model.
   Assumes rsj_defines.vh on the include path. */
`timescale 1ns/1ps
`include "rsj_defines.vh"
module tb_remote_sys_jog;
  logic I_CLK, I_SRST, i_EXT_POINT_MODE, i_LINK_OK, i_PENDANT_ACTIVE, i_PC_SW_ACTIVE;
  logic i_HOME_REQUEST_BIT, i_START_REQUEST_BIT, i_STOP_REQUEST_BIT, i_ERROR_RESET_REQUEST_BIT;
  logic i_PROG_EXECUTING, i_HOMING, i_ROBOT_MOVING, i_AT_TARGET, i_PAUSED, i_ALL_AXES_HOME;
  logic i_HOME_DONE, i_ERROR_EVENT, i_INCHING_SELECT, i_LOW_SPEED_JOG_SELECT;
  logic i_HIGH_SPEED_JOG_SELECT, i_JOG_DIRECTION_SELECT, o_HOME_CMD, o_START_CMD, o_STEP_HALT;
  logic o_ERROR_CLEAR, o_JOG_DIR, o_RUNNING_STATUS_BIT, o_ERROR_STATUS_BIT;
  logic o_IN_POSITION_STATUS_BIT, o_HOMED_STATUS_BIT, o_JOG_READY;
  logic [3:0] i_AXIS_JOG_REQUEST, o_JOG_AXIS_MOVE, o_AXIS_JOGGING, pm;
  logic [1:0] o_JOG_SPEED;
  logic [2:0] o_SPARE_STATUS, sel;
  logic [7:0] q[$];
  logic [7:0] st[7] = '{8'h4b, 8'h22, 8'h18, 8'hc9, 8'h9a, 8'h8c, 8'h00};
  logic [31:0] lfsr = 32'h4366657c;
  int n_mismatch = 0, samples_checked = 0, cyc = 0;

  remote_sys_jog i_remote_sys_jog (.*);
  fb_master i_fb_master (.clk(I_CLK), .ready(o_JOG_READY), .req(i_AXIS_JOG_REQUEST), .inch(i_INCHING_SELECT),
    .low(i_LOW_SPEED_JOG_SELECT), .high(i_HIGH_SPEED_JOG_SELECT), .dir(i_JOG_DIRECTION_SELECT));

  initial begin
    I_CLK = 1'b0;
    forever #10 I_CLK = ~I_CLK;
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task cb(input string nm, input logic e, input logic g);
    cmp(nm, {7'h0, e}, {7'h0, g});
  endtask
  task take(input string nm, input logic [7:0] g);
    cmp(nm, q.size() ? q.pop_front() : 8'hff, g);
  endtask
  task wt(input int n);
    repeat (n) @(negedge I_CLK);
  endtask
  task results;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Sampled off the edge; an unexpected result meets an empty queue
  always @(negedge I_CLK) begin
    if (!I_SRST && o_HOME_CMD) take("home", 8'h01);
    if (!I_SRST && o_START_CMD) take("start", 8'h02);
    if (!I_SRST && o_ERROR_CLEAR) take("errclr", 8'h03);
    if (o_JOG_AXIS_MOVE != 4'h0 && o_JOG_AXIS_MOVE !== pm) take("jog", {1'b1, o_JOG_AXIS_MOVE, o_JOG_SPEED, o_JOG_DIR});
    pm = o_JOG_AXIS_MOVE;
  end

  always @(posedge I_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("[ERR] timeout exp 0 got 1");
      results();
    end
  end

  initial begin
    I_SRST = 1'b1;
    {i_EXT_POINT_MODE, i_PENDANT_ACTIVE, i_PC_SW_ACTIVE, i_HOME_REQUEST_BIT, i_START_REQUEST_BIT} = 5'h0;
    {i_STOP_REQUEST_BIT, i_ERROR_RESET_REQUEST_BIT, i_PROG_EXECUTING, i_HOMING, i_ROBOT_MOVING} = 5'h0;
    {i_AT_TARGET, i_PAUSED, i_ALL_AXES_HOME, i_HOME_DONE, i_ERROR_EVENT} = 5'h0;
    i_LINK_OK = 1'b1;
    wt(20);
    I_SRST = 1'b0;
    wt(2);
    cmp("spare", 8'h00, {5'h0, o_SPARE_STATUS});
    cb("ready", 1'b1, o_JOG_READY);
    q.push_back(8'h01);
    i_HOME_REQUEST_BIT = 1'b1;
    wt(4);
    q.push_back(8'h02);
    {i_HOME_REQUEST_BIT, i_START_REQUEST_BIT} = 2'b01;
    wt(2);
    {i_START_REQUEST_BIT, i_STOP_REQUEST_BIT} = 2'b01;
    wt(2);
    cb("halt", 1'b1, o_STEP_HALT);
    {i_HOME_REQUEST_BIT, i_START_REQUEST_BIT} = 2'b11;
    wt(2);
    {i_HOME_REQUEST_BIT, i_START_REQUEST_BIT, i_EXT_POINT_MODE} = 3'b001;
    wt(1);
    q.push_back(8'h01);
    i_HOME_REQUEST_BIT = 1'b1;
    wt(2);
    {i_HOME_REQUEST_BIT, i_STOP_REQUEST_BIT, i_EXT_POINT_MODE, i_HOME_DONE} = 4'b0001;
    wt(2);
    cb("homed", 1'b0, o_HOMED_STATUS_BIT);
    i_ALL_AXES_HOME = 1'b1;
    wt(2);
    cb("homed", 1'b1, o_HOMED_STATUS_BIT);
    i_HOME_DONE = 1'b0;
    $display("test system bits done");
    foreach (st[k]) begin
      {i_EXT_POINT_MODE, i_PROG_EXECUTING, i_HOMING, i_ROBOT_MOVING, i_AT_TARGET, i_PAUSED} = st[k][7:2];
      wt(2);
      cb("running", st[k][1], o_RUNNING_STATUS_BIT);
      cb("inpos", st[k][0], o_IN_POSITION_STATUS_BIT);
    end
    i_ERROR_EVENT = 1'b1;
    wt(1);
    {i_ERROR_EVENT, i_PROG_EXECUTING, i_ERROR_RESET_REQUEST_BIT} = 3'b011;
    wt(2);
    cb("error", 1'b1, o_ERROR_STATUS_BIT);
    i_fb_master.jog(2'd2, 3'b100, 1'b0, 1'b1, 2);
    q.push_back(8'h03);
    i_PROG_EXECUTING = 1'b0;
    wt(2);
    cb("error", 1'b0, o_ERROR_STATUS_BIT);
    i_ERROR_RESET_REQUEST_BIT = 1'b0;
    $display("test error done");
    for (int k = 0; k < 8; k++) begin
      lfsr = nxt(lfsr);
      sel = (k < 3) ? 3'b001 << k : lfsr[4:2];
      if (sel != 3'h0) q.push_back({1'b1, 4'h1 << lfsr[1:0],
        sel[2] ? `RSJ_SPD_INCH : sel[1] ? `RSJ_SPD_LOW : `RSJ_SPD_HIGH, lfsr[5]});
      i_fb_master.jog(lfsr[1:0], sel, lfsr[5], 1'b0, 3);
    end
    q.push_back({1'b1, 4'h2, `RSJ_SPD_LOW, 1'b1});
    fork
      i_fb_master.jog(2'd1, 3'b010, 1'b1, 1'b0, 6);
      begin
        wt(5);
        i_LINK_OK = 1'b0;
        wt(2);
        cmp("linkdrop", 8'h00, {4'h0, o_JOG_AXIS_MOVE});
        i_LINK_OK = 1'b1;
      end
    join
    wt(4);
    cmp("queue", 8'h00, 8'(q.size()));
    $display("test jog done");
    results();
  end
endmodule // tb_remote_sys_jog
